// [rtl/hp_consts.vh]
// Function
// [R1] The host reads the three receive bytes only after the receive full flag shows data, by polling or by interrupt.
// [R2] The host writes the three transmit bytes only while the transmit empty flag is set.
// [R3] The device moves the three host transmit bytes into its dsp-side receive word.
// [R4] The device drives the host-visible status bits from its own logic, readable by the host at any time.
// [R5] The host tolerates a transient status value on one read and trusts the next poll.
// [R6] A host read held long enough, with enough spacing between reads, returns a stable status value.
// [R7] The host reads the two dsp-to-host flags twice for consensus when it treats them as a code.
// [R8] The host changes the command vector only while the command request bit is clear.
// [R9] The host may cancel a pending command by clearing the command request bit before recognition.
// [R10] The device may still take the command after the host has cleared the command request bit.
// [R11] The host never changes the command vector in the write that clears the command request bit.
// [R12] The device synchronizes each host-written status bit into its own clock domain one bit at a time.
// [R13] The device recognises a synchronized command, captures its vector and clears the command request bit.
`ifndef HP_CONSTS_VH
`define HP_CONSTS_VH

// host side byte addresses
`define HP_HA_CTRL        3'h0
`define HP_HA_CMD         3'h1
`define HP_HA_STATUS      3'h2
`define HP_HA_BYTE_HIGH   3'h5
`define HP_HA_BYTE_MIDDLE 3'h6
`define HP_HA_BYTE_LOW    3'h7

// host control byte fields
`define HP_CTRL_RX_REQ_EN 0
`define HP_CTRL_TX_REQ_EN 1
`define HP_CTRL_FLAG_A    3
`define HP_CTRL_FLAG_B    4
`define HP_CTRL_DMA       5
`define HP_CTRL_MASK      8'h3B

// host command byte fields
`define HP_CMD_BIT        7
`define HP_VEC_W          5

// dsp side register addresses
`define HP_DA_RX_WORD     3'h0
`define HP_DA_TX_WORD     3'h1
`define HP_DA_STATUS      3'h2
`define HP_DA_FLAGS       3'h3
`define HP_DA_VECTOR      3'h4
`define HP_DA_IRQ_STATUS  3'h5
`define HP_DA_IRQ_CLEAR   3'h6
`define HP_DA_IRQ_ENABLE  3'h7

// interrupt events
`define HP_EV_RX_FULL     0
`define HP_EV_TX_EMPTY    1
`define HP_EV_COMMAND     2
`define HP_EV_COUNT       3

// synchronizer depth and host-written bits crossing it
`define HP_SYNC_STAGES    2
`define HP_SYNC_BITS      6

`endif

// [rtl/hp_bit_sync.v]
`timescale 1ns/100ps
// one two-stage synchronizer per bit, no bit depends on another
module hp_bit_sync #(
  parameter WIDTH = 6
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg safe_reg;
      // first stage feeds only the second stage
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg <= 1'b0;
          safe_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          safe_reg <= meta_reg;
        end
      end
      assign sync_out[i] = safe_reg;
    end
  endgenerate

endmodule

// [rtl/hp_irq_regs.v]
`timescale 1ns/100ps
// sticky event bits, write-one-to-clear, enable mask, one level output
module hp_irq_regs #(
  parameter N = 3
) (
  input  wire         sys_clk,
  input  wire         rst_n,
  input  wire [N-1:0] event_pulse,
  input  wire         clear_wr,
  input  wire         enable_wr,
  input  wire [N-1:0] wr_data,
  output wire [N-1:0] status_out,
  output reg  [N-1:0] enable_reg,
  output wire         irq
);

  reg [N-1:0] status_reg;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_ev
      // set wins over a clear in the same cycle, so no event is lost
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          status_reg[i] <= 1'b0;
        end else if (event_pulse[i]) begin
          status_reg[i] <= 1'b1;
        end else if (clear_wr && wr_data[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // enable mask
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= {N{1'b0}};
    end else if (enable_wr) begin
      enable_reg <= wr_data;
    end
  end

  assign status_out = status_reg;
  assign irq        = |(status_reg & enable_reg);

endmodule

// [rtl/hp_host_port.v]
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "hp_consts.vh"
// parallel host port: byte-wide host side, word-wide dsp side
module hp_host_port #(
  parameter WORD_W = 24
) (
  input  wire              sys_clk,
  input  wire              rst_n,
  // host pins, sampled as synchronous inputs
  input  wire              port_enable_strobe_n,
  input  wire              host_rw,
  input  wire [2:0]        host_addr,
  input  wire [7:0]        host_data_in,
  output reg  [7:0]        host_data_out,
  output wire              host_data_oe,
  output wire              port_request_line_n,
  // dsp register port
  input  wire [2:0]        dsp_addr,
  input  wire [WORD_W-1:0] dsp_wdata,
  input  wire              dsp_wr,
  input  wire              dsp_rd,
  output reg  [WORD_W-1:0] dsp_rdata,
  output reg               command_taken,
  output wire              irq
);

  // host access tracking
  reg                    strobe_q_reg;
  reg                    rw_q_reg;
  reg  [2:0]             addr_q_reg;
  reg  [7:0]             din_q_reg;
  // host-visible registers
  reg  [7:0]             ctrl_reg;
  reg                    command_request_bit;
  reg  [`HP_VEC_W-1:0]   command_vector;
  reg  [7:0]             transmit_byte_high;
  reg  [7:0]             transmit_byte_middle;
  reg  [7:0]             transmit_byte_low;
  reg  [7:0]             receive_byte_high;
  reg  [7:0]             receive_byte_middle;
  reg  [7:0]             receive_byte_low;
  reg                    receive_full_flag;
  reg                    transmit_empty_flag;
  // dsp side state
  reg  [WORD_W-1:0]      dsp_side_receive_word;
  reg                    dsp_side_receive_full;
  reg  [WORD_W-1:0]      dsp_tx_word_reg;
  reg                    dsp_tx_pending_reg;
  reg                    dsp_to_host_flag_a;
  reg                    dsp_to_host_flag_b;
  reg  [`HP_VEC_W-1:0]   vector_cap_reg;
  reg                    cmd_seen_reg;

  wire                   host_active;
  wire                   host_write_done;
  wire                   host_read_done;
  wire                   host_read_start;
  wire                   to_dsp_move;
  wire                   to_host_move;
  wire                   cmd_recognise;
  wire                   transmitter_ready_flag;
  wire                   request_active;
  wire                   dsp_side_transmit_empty;
  wire [`HP_SYNC_BITS-1:0] host_bits;
  wire [`HP_SYNC_BITS-1:0] host_bits_sync;
  wire                   dma_sync;
  wire                   host_to_dsp_flag_b;
  wire                   host_to_dsp_flag_a;
  wire                   command_pending_flag;
  wire                   host_tx_empty_sync;
  wire                   host_rx_full_sync;
  wire [`HP_EV_COUNT-1:0] events;
  wire [`HP_EV_COUNT-1:0] irq_status;
  wire [`HP_EV_COUNT-1:0] irq_enable;
  wire                   wr_irq_clear;
  wire                   wr_irq_enable;
  reg  [7:0]             host_read_mux;

  // previous-cycle copy of the host pins for edge detection
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q_reg <= 1'b1;
      rw_q_reg     <= 1'b1;
      addr_q_reg   <= 3'h0;
      din_q_reg    <= 8'h00;
    end else begin
      strobe_q_reg <= port_enable_strobe_n;
      rw_q_reg     <= host_rw;
      addr_q_reg   <= host_addr;
      din_q_reg    <= host_data_in;
    end
  end

  // writes land at strobe release, where host data is set up
  assign host_active     = !port_enable_strobe_n;
  assign host_read_start = host_active && strobe_q_reg && host_rw;
  assign host_write_done = !strobe_q_reg && port_enable_strobe_n && !rw_q_reg;
  assign host_read_done  = !strobe_q_reg && port_enable_strobe_n && rw_q_reg;

  // host to dsp word move and dsp to host word move
  assign to_dsp_move   = !transmit_empty_flag && !dsp_side_receive_full;   // [R3]
  assign to_host_move  = dsp_tx_pending_reg && !receive_full_flag;
  assign cmd_recognise = command_pending_flag && !cmd_seen_reg;          // [R13]

  // status seen by the host, all from device flops
  assign transmitter_ready_flag  = transmit_empty_flag && !dsp_side_receive_full;   // [R4]
  assign request_active = (ctrl_reg[`HP_CTRL_RX_REQ_EN] && receive_full_flag) ||
                          (ctrl_reg[`HP_CTRL_TX_REQ_EN] && transmit_empty_flag);   // [R4]
  assign port_request_line_n     = !request_active;
  assign dsp_side_transmit_empty = !dsp_tx_pending_reg;

  // host control byte and dsp-to-host flags are plain storage
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 8'h00;
    end else if (host_write_done && addr_q_reg == `HP_HA_CTRL) begin
      ctrl_reg <= din_q_reg & `HP_CTRL_MASK;
    end
  end

  // command byte: a host write setting the bit beats the device clear
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      command_request_bit <= 1'b0;
      command_vector      <= {`HP_VEC_W{1'b0}};
    end else if (host_write_done && addr_q_reg == `HP_HA_CMD) begin
      command_request_bit <= din_q_reg[`HP_CMD_BIT];
      command_vector      <= din_q_reg[`HP_VEC_W-1:0];
    end else if (cmd_recognise) begin
      command_request_bit <= 1'b0;                                          // [R13]
    end
  end

  // transmit bytes; the low byte completes the word
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_byte_high   <= 8'h00;
      transmit_byte_middle <= 8'h00;
      transmit_byte_low    <= 8'h00;
      transmit_empty_flag  <= 1'b1;
    end else begin
      if (to_dsp_move) begin
        transmit_empty_flag <= 1'b1;                                        // [R3]
      end
      if (host_write_done) begin
        case (addr_q_reg)
          `HP_HA_BYTE_HIGH: begin
            transmit_byte_high <= din_q_reg;
          end
          `HP_HA_BYTE_MIDDLE: begin
            transmit_byte_middle <= din_q_reg;
          end
          `HP_HA_BYTE_LOW: begin
            transmit_byte_low   <= din_q_reg;
            transmit_empty_flag <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // receive bytes; a host read of the low byte frees them
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_byte_high   <= 8'h00;
      receive_byte_middle <= 8'h00;
      receive_byte_low    <= 8'h00;
      receive_full_flag   <= 1'b0;
    end else begin
      if (host_read_done && addr_q_reg == `HP_HA_BYTE_LOW) begin
        receive_full_flag <= 1'b0;
      end
      if (to_host_move) begin
        receive_byte_high   <= dsp_tx_word_reg[23:16];
        receive_byte_middle <= dsp_tx_word_reg[15:8];
        receive_byte_low    <= dsp_tx_word_reg[7:0];
        receive_full_flag   <= 1'b1;
      end
    end
  end

  // host read data: the whole access sees one snapshot
  always @* begin
    case (host_addr)
      `HP_HA_CTRL: begin
        host_read_mux = ctrl_reg;
      end
      `HP_HA_CMD: begin
        host_read_mux = {command_request_bit, 2'b00, command_vector};
      end
      `HP_HA_STATUS: begin
        host_read_mux = {request_active, ctrl_reg[`HP_CTRL_DMA], 1'b0, dsp_to_host_flag_b,
                         dsp_to_host_flag_a, transmitter_ready_flag, transmit_empty_flag,
                         receive_full_flag};                                // [R4]
      end
      `HP_HA_BYTE_HIGH: begin
        host_read_mux = receive_byte_high;
      end
      `HP_HA_BYTE_MIDDLE: begin
        host_read_mux = receive_byte_middle;
      end
      `HP_HA_BYTE_LOW: begin
        host_read_mux = receive_byte_low;
      end
      default: begin
        host_read_mux = 8'h00;
      end
    endcase
  end

  // captured at strobe assertion and held, so flags never tear mid-read
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_out <= 8'h00;
    end else if (host_read_start) begin
      host_data_out <= host_read_mux;                                       // [R6]
    end
  end

  // drive only after the snapshot is in place
  assign host_data_oe = host_active && !strobe_q_reg && rw_q_reg && host_rw;

  // each of the six bits listed here crosses on its own synchronizer; the vector and request enables do not
  assign host_bits = {ctrl_reg[`HP_CTRL_DMA], ctrl_reg[`HP_CTRL_FLAG_B], ctrl_reg[`HP_CTRL_FLAG_A],
                      command_request_bit, transmit_empty_flag, receive_full_flag};

  hp_bit_sync #(
    .WIDTH (`HP_SYNC_BITS)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (host_bits),
    .sync_out (host_bits_sync)                                              // [R12]
  );

  assign dma_sync             = host_bits_sync[5];
  assign host_to_dsp_flag_b   = host_bits_sync[4];
  assign host_to_dsp_flag_a   = host_bits_sync[3];
  assign command_pending_flag = host_bits_sync[2];
  assign host_tx_empty_sync   = host_bits_sync[1];
  assign host_rx_full_sync    = host_bits_sync[0];

  // dsp receive word; a dsp read frees it for the next host word
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_side_receive_word <= {WORD_W{1'b0}};
      dsp_side_receive_full <= 1'b0;
    end else begin
      if (dsp_rd && dsp_addr == `HP_DA_RX_WORD) begin
        dsp_side_receive_full <= 1'b0;
      end
      if (to_dsp_move) begin
        dsp_side_receive_word <= {transmit_byte_high, transmit_byte_middle, transmit_byte_low}; // [R3]
        dsp_side_receive_full <= 1'b1;
      end
    end
  end

  // dsp transmit word and flags toward the host
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_tx_word_reg    <= {WORD_W{1'b0}};
      dsp_tx_pending_reg <= 1'b0;
      dsp_to_host_flag_a <= 1'b0;
      dsp_to_host_flag_b <= 1'b0;
    end else begin
      if (to_host_move) begin
        dsp_tx_pending_reg <= 1'b0;
      end
      if (dsp_wr && dsp_addr == `HP_DA_TX_WORD) begin
        dsp_tx_word_reg    <= dsp_wdata;
        dsp_tx_pending_reg <= 1'b1;
      end
      if (dsp_wr && dsp_addr == `HP_DA_FLAGS) begin
        dsp_to_host_flag_a <= dsp_wdata[0];                                 // [R4]
        dsp_to_host_flag_b <= dsp_wdata[1];
      end
    end
  end

  // late recognition is allowed: the synced bit lags a host cancel
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_seen_reg   <= 1'b0;
      vector_cap_reg <= {`HP_VEC_W{1'b0}};
      command_taken  <= 1'b0;
    end else begin
      cmd_seen_reg  <= command_pending_flag;                                // [R10]
      command_taken <= cmd_recognise;
      if (cmd_recognise) begin
        vector_cap_reg <= command_vector;                                   // [R13]
      end
    end
  end

  // interrupt events toward dsp software
  assign events[`HP_EV_RX_FULL]  = to_dsp_move;
  assign events[`HP_EV_TX_EMPTY] = to_host_move;
  assign events[`HP_EV_COMMAND]  = cmd_recognise;
  assign wr_irq_clear  = dsp_wr && dsp_addr == `HP_DA_IRQ_CLEAR;
  assign wr_irq_enable = dsp_wr && dsp_addr == `HP_DA_IRQ_ENABLE;

  hp_irq_regs #(
    .N (`HP_EV_COUNT)
  ) u_irq (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .event_pulse (events),
    .clear_wr    (wr_irq_clear),
    .enable_wr   (wr_irq_enable),
    .wr_data     (dsp_wdata[`HP_EV_COUNT-1:0]),
    .status_out  (irq_status),
    .enable_reg  (irq_enable),
    .irq         (irq)
  );

  // dsp read data, one cycle after the read strobe
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_rdata <= {WORD_W{1'b0}};
    end else if (dsp_rd) begin
      case (dsp_addr)
        `HP_DA_RX_WORD: begin
          dsp_rdata <= dsp_side_receive_word;
        end
        `HP_DA_STATUS: begin
          dsp_rdata <= {{(WORD_W-8){1'b0}}, host_rx_full_sync, host_tx_empty_sync,
                        command_pending_flag, dma_sync, host_to_dsp_flag_b, host_to_dsp_flag_a,
                        dsp_side_transmit_empty, dsp_side_receive_full};     // [R12]
        end
        `HP_DA_FLAGS: begin
          dsp_rdata <= {{(WORD_W-2){1'b0}}, dsp_to_host_flag_b, dsp_to_host_flag_a};
        end
        `HP_DA_VECTOR: begin
          dsp_rdata <= {{(WORD_W-`HP_VEC_W){1'b0}}, vector_cap_reg};
        end
        `HP_DA_IRQ_STATUS: begin
          dsp_rdata <= {{(WORD_W-`HP_EV_COUNT){1'b0}}, irq_status};
        end
        `HP_DA_IRQ_ENABLE: begin
          dsp_rdata <= {{(WORD_W-`HP_EV_COUNT){1'b0}}, irq_enable};
        end
        default: begin
          dsp_rdata <= {WORD_W{1'b0}};
        end
      endcase
    end
  end

endmodule

// [bench/hp_host_port_checker.sv]
`timescale 1ns/100ps
// port-level checker for the host port; pins seen only at the top ports
module hp_host_port_checker #(
  parameter WORD_W = 24
) (
  input logic              sys_clk,
  input logic              rst_n,
  input logic              port_enable_strobe_n,
  input logic              host_rw,
  input logic [2:0]        host_addr,
  input logic [7:0]        host_data_in,
  input logic [7:0]        host_data_out,
  input logic              host_data_oe,
  input logic              dsp_wr,
  input logic              dsp_rd,
  input logic [WORD_W-1:0] dsp_rdata,
  input logic              command_taken,
  input logic              irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic       prev_s_reg;
  logic       prev_rw_reg;
  logic       prev_cmd_reg;
  logic [3:0] age_reg;
  wire        set_rel = port_enable_strobe_n && !prev_s_reg && !prev_rw_reg && prev_cmd_reg;
  // pin history: spots a released write that sets the command bit, and ages it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_s_reg <= 1'b1;
      prev_rw_reg <= 1'b1;
      prev_cmd_reg <= 1'b0;
      age_reg <= 4'hF;
    end else begin
      prev_s_reg <= port_enable_strobe_n;
      prev_rw_reg <= host_rw;
      prev_cmd_reg <= (host_addr == 3'h1) && host_data_in[7];
      age_reg <= set_rel ? 4'h0 : ((age_reg == 4'hF) ? age_reg : age_reg + 4'h1);
    end
  end
  oe_gate_a: assert property (host_data_oe |-> !port_enable_strobe_n && host_rw)
    else $error("host data driven outside a read");
  oe_on_a: assert property ((!port_enable_strobe_n && $past(port_enable_strobe_n) && host_rw) ##1
    (!port_enable_strobe_n && host_rw) |-> host_data_oe) else $error("read data not driven");
  out_stable_a: assert property (!port_enable_strobe_n && !$past(port_enable_strobe_n) &&
    !$past(port_enable_strobe_n, 2) |-> $stable(host_data_out)) else $error("read data moved in access");
  out_load_a: assert property ($changed(host_data_out) |-> !$past(port_enable_strobe_n) &&
    $past(port_enable_strobe_n, 2) && $past(host_rw)) else $error("read data changed off read start");
  rdata_hold_a: assert property (!$past(dsp_rd) |-> $stable(dsp_rdata))
    else $error("dsp read data changed without read");
  taken_pulse_a: assert property (command_taken |=> !command_taken)
    else $error("command taken longer than one cycle");
  taken_after_set_a: assert property (set_rel |-> ##[2:8] command_taken)
    else $error("command not taken after set");
  taken_cause_a: assert property (command_taken |-> age_reg <= 4'h8)
    else $error("command taken without recent set");
  irq_fall_a: assert property ($fell(irq) |-> $past(dsp_wr))
    else $error("interrupt dropped without register write");
endmodule
bind hp_host_port hp_host_port_checker #(.WORD_W(WORD_W)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .port_enable_strobe_n(port_enable_strobe_n), .host_rw(host_rw), .host_addr(host_addr),
  .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
  .dsp_wr(dsp_wr), .dsp_rd(dsp_rd), .dsp_rdata(dsp_rdata), .command_taken(command_taken), .irq(irq));

// [bench/hp_host_model.sv]
`timescale 1ns/100ps
// external host: strobed byte accesses, no clock of its own beyond pacing
module hp_host_model (
  input  logic       sys_clk,
  input  logic [7:0] host_data_out,
  input  logic       host_data_oe,
  output logic       strobe_n,
  output logic       host_rw,
  output logic [2:0] host_addr,
  output logic [7:0] host_data_in
);
  // idle pins at time zero
  initial begin
    strobe_n = 1'b1;
    host_rw = 1'b1;
    host_addr = 3'h0;
    host_data_in = 8'h00;
  end
  // write lands at strobe release; released data inverted so stale bits show
  task hwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    strobe_n <= 1'b0;
    host_rw <= 1'b0;
    host_addr <= a;
    host_data_in <= d;
    @(posedge sys_clk);
    strobe_n <= 1'b1;
    @(posedge sys_clk);
    host_data_in <= ~d;
  endtask
  // extended read, strobe low for three edges so the held snapshot is seen
  task hrd(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(posedge sys_clk);
    strobe_n <= 1'b0;
    host_rw <= 1'b1;
    host_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    d = host_data_out;
    oe = host_data_oe;
    @(posedge sys_clk);
    @(posedge sys_clk);
    strobe_n <= 1'b1;
  endtask
  // a poll may see a moving bit; the next pass settles it
  task poll(input logic [2:0] a, input int b, input logic v);
    logic [7:0] d;
    logic       oe;
    d = ~{8{v}};
    for (int i = 0; i < 30 && d[b] !== v; i++) hrd(a, d, oe);
  endtask
  // bytes written only once transmit empty shows
  task send_word(input logic [23:0] w);
    poll(3'h2, 1, 1'b1);
    hwr(3'h5, w[23:16]);
    hwr(3'h6, w[15:8]);
    hwr(3'h7, w[7:0]);
  endtask
  // bytes read only once receive full shows
  task recv_word(output logic [23:0] w);
    logic oe;
    poll(3'h2, 0, 1'b1);
    hrd(3'h5, w[23:16], oe);
    hrd(3'h6, w[15:8], oe);
    hrd(3'h7, w[7:0], oe);
  endtask
  // flag pair read twice until both reads agree
  task flags2(output logic [1:0] f);
    logic [7:0] d1;
    logic [7:0] d2;
    logic       oe;
    d1 = 8'h00;
    d2 = 8'hFF;
    for (int i = 0; i < 8 && d1[4:3] !== d2[4:3]; i++) begin
      hrd(3'h2, d1, oe);
      hrd(3'h2, d2, oe);
    end
    f = d2[4:3];
  endtask
  // vector changed only while the command bit reads clear
  task set_cmd(input logic [4:0] v);
    poll(3'h1, 7, 1'b0);
    hwr(3'h1, {3'b100, v});
  endtask
  // cancel keeps the vector as it was
  task cancel_cmd(input logic [4:0] v);
    hwr(3'h1, {3'b000, v});
  endtask
endmodule

// [bench/hp_host_port_bench.sv]
`timescale 1ns/100ps
// self-checking bench: host model on the pins, dsp port driven here
module hp_host_port_bench;
  typedef struct {bit dsp; logic [2:0] a; logic [23:0] e;} hp_row_t;
  logic        sys_clk, rst_n, strobe_n, host_rw, host_oe, req_n, dsp_wr, dsp_rd, taken, irq;
  logic [2:0]  host_addr, dsp_addr;
  logic [7:0]  host_din, host_dout;
  logic [23:0] dsp_wdata, dsp_rdata, v;
  logic [1:0]  f;
  int          mismatches, check_count, cyc, taken_cnt;
  // values after any reset
  hp_row_t     rows [11] = '{'{1'b0, 3'h0, 24'h00}, '{1'b0, 3'h1, 24'h00}, '{1'b0, 3'h2, 24'h06},
    '{1'b0, 3'h3, 24'h00}, '{1'b0, 3'h4, 24'h00}, '{1'b1, 3'h2, 24'h42}, '{1'b1, 3'h3, 24'h00},
    '{1'b1, 3'h4, 24'h00}, '{1'b1, 3'h5, 24'h00}, '{1'b1, 3'h6, 24'h00}, '{1'b1, 3'h7, 24'h00}};

  hp_host_model host_u (.sys_clk(sys_clk), .host_data_out(host_dout), .host_data_oe(host_oe),
    .strobe_n(strobe_n), .host_rw(host_rw), .host_addr(host_addr), .host_data_in(host_din));
  hp_host_port #(.WORD_W(24)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .port_enable_strobe_n(strobe_n),
    .host_rw(host_rw), .host_addr(host_addr), .host_data_in(host_din), .host_data_out(host_dout),
    .host_data_oe(host_oe), .port_request_line_n(req_n), .dsp_addr(dsp_addr), .dsp_wdata(dsp_wdata),
    .dsp_wr(dsp_wr), .dsp_rd(dsp_rd), .dsp_rdata(dsp_rdata), .command_taken(taken), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // cycle ceiling against hangs; also counts command pulses
  always @(posedge sys_clk) begin
    cyc++;
    if (taken === 1'b1) taken_cnt++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task dwr(input logic [2:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    dsp_addr <= a;
    dsp_wdata <= d;
    dsp_wr <= 1'b1;
    @(posedge sys_clk);
    dsp_wr <= 1'b0;
  endtask
  // read data appears in the cycle after the strobe and holds until the next read
  task drd(input logic [2:0] a, output logic [23:0] d);
    @(posedge sys_clk);
    dsp_addr <= a;
    dsp_rd <= 1'b1;
    @(posedge sys_clk);
    dsp_rd <= 1'b0;
    @(negedge sys_clk);
    d = dsp_rdata;
  endtask
  // host reads also prove the data pins were driven
  task rd_any(input bit dsp, input logic [2:0] a, output logic [23:0] d);
    logic [7:0] b;
    logic       oe;
    if (dsp) drd(a, d);
    else begin
      host_u.hrd(a, b, oe);
      d = {16'h0000, b};
      chk({23'h0, oe}, 24'h1);
    end
  endtask
  task check_rows();
    foreach (rows[i]) begin
      rd_any(rows[i].dsp, rows[i].a, v);
      chk(v, rows[i].e);
    end
    chk({23'h0, req_n}, 24'h1);
    chk({23'h0, irq}, 24'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    dsp_addr = 3'h0;
    dsp_wdata = 24'h0;
    dsp_wr = 1'b0;
    dsp_rd = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    check_rows();
    // writes to status and gap addresses must change nothing
    host_u.hwr(3'h2, 8'hFF);
    host_u.hwr(3'h3, 8'hFF);
    check_rows();
    // host word into the dsp side, then the interrupt raised, masked, cleared
    host_u.send_word(24'hABCDEF);
    for (int i = 0; i < 20 && v[0] !== 1'b1; i++) drd(3'h2, v);
    drd(3'h2, v);
    chk(v, 24'h43);
    drd(3'h5, v);
    chk(v, 24'h1);
    dwr(3'h7, 24'h1);
    @(negedge sys_clk);
    chk({23'h0, irq}, 24'h1);
    dwr(3'h7, 24'h0);
    @(negedge sys_clk);
    chk({23'h0, irq}, 24'h0);
    dwr(3'h7, 24'h1);
    dwr(3'h6, 24'h1);
    @(negedge sys_clk);
    chk({23'h0, irq}, 24'h0);
    drd(3'h0, v);
    chk(v, 24'hABCDEF);
    drd(3'h2, v);
    chk(v, 24'h42);
    // dsp word out to the host with the receive request enabled
    host_u.hwr(3'h0, 8'h01);
    dwr(3'h1, 24'h123456);
    host_u.poll(3'h2, 0, 1'b1);
    rd_any(1'b0, 3'h2, v);
    chk(v, 24'h87);
    chk({23'h0, req_n}, 24'h0);
    host_u.recv_word(v);
    chk(v, 24'h123456);
    rd_any(1'b0, 3'h2, v);
    chk(v, 24'h06);
    chk({23'h0, req_n}, 24'h1);
    drd(3'h5, v);
    chk(v, 24'h2);
    // flag pair, full control byte, synced copies, then reset in mid-run
    dwr(3'h3, 24'h3);
    host_u.flags2(f);
    chk({22'h0, f}, 24'h3);
    host_u.hwr(3'h0, 8'hFF);
    rd_any(1'b0, 3'h0, v);
    chk(v, 24'h3B);
    rd_any(1'b0, 3'h2, v);
    chk(v, 24'hDE);
    chk({23'h0, req_n}, 24'h0);
    drd(3'h2, v);
    chk(v, 24'h5E);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    check_rows();
    // command taken with its vector, then a late cancel still taken
    host_u.set_cmd(5'h15);
    for (int i = 0; i < 12 && taken_cnt < 1; i++) @(posedge sys_clk);
    chk(taken_cnt[23:0], 24'h1);
    drd(3'h4, v);
    chk(v, 24'h15);
    rd_any(1'b0, 3'h1, v);
    chk(v, 24'h15);
    drd(3'h5, v);
    chk(v, 24'h4);
    host_u.set_cmd(5'h0A);
    host_u.cancel_cmd(5'h0A);
    for (int i = 0; i < 12 && taken_cnt < 2; i++) @(posedge sys_clk);
    chk(taken_cnt[23:0], 24'h2);
    drd(3'h4, v);
    chk(v, 24'h0A);
    rd_any(1'b0, 3'h1, v);
    chk(v, 24'h0A);
    end_of_test();
  end
endmodule
